// file: hdl/apc_pkg.sv
// package: audio path control register map, field layout, frame format and types
`default_nettype none

package apc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned N_REGS = 5;
  localparam int unsigned IDX_W  = 3;

  localparam logic [ADDR_W-1:0] ADDR_ADC_GAIN_AND_STEREO_CLOCK = 10'h18d;
  localparam logic [ADDR_W-1:0] ADDR_VOICE_DAC_VOLUME_MUTE     = 10'h18e;
  localparam logic [ADDR_W-1:0] ADDR_LEFT_DAC_VOLUME_MUTE      = 10'h18f;
  localparam logic [ADDR_W-1:0] ADDR_RIGHT_DAC_VOLUME_MUTE     = 10'h190;
  localparam logic [ADDR_W-1:0] ADDR_AMP_MUTE_LEFT_MIXER       = 10'h191;

  localparam logic [N_REGS-1:0][ADDR_W-1:0] REG_ADDRS = {
    ADDR_AMP_MUTE_LEFT_MIXER,
    ADDR_RIGHT_DAC_VOLUME_MUTE,
    ADDR_LEFT_DAC_VOLUME_MUTE,
    ADDR_VOICE_DAC_VOLUME_MUTE,
    ADDR_ADC_GAIN_AND_STEREO_CLOCK
  };

  localparam logic [IDX_W-1:0] IDX_ADC_GAIN_AND_STEREO_CLOCK = 3'h0;
  localparam logic [IDX_W-1:0] IDX_VOICE_DAC_VOLUME_MUTE     = 3'h1;
  localparam logic [IDX_W-1:0] IDX_LEFT_DAC_VOLUME_MUTE      = 3'h2;
  localparam logic [IDX_W-1:0] IDX_RIGHT_DAC_VOLUME_MUTE     = 3'h3;
  localparam logic [IDX_W-1:0] IDX_AMP_MUTE_LEFT_MIXER       = 3'h4;

  // implemented bits; reserved bits are zero here
  localparam logic [DATA_W-1:0] MASK_ADC_GAIN_AND_STEREO_CLOCK = 8'h7f;
  localparam logic [DATA_W-1:0] MASK_DAC_VOLUME_MUTE           = 8'hbf;
  localparam logic [DATA_W-1:0] MASK_AMP_MUTE_LEFT_MIXER       = 8'hb7;

  localparam logic [N_REGS-1:0][DATA_W-1:0] WRITE_MASKS = {
    MASK_AMP_MUTE_LEFT_MIXER,
    MASK_DAC_VOLUME_MUTE,
    MASK_DAC_VOLUME_MUTE,
    MASK_DAC_VOLUME_MUTE,
    MASK_ADC_GAIN_AND_STEREO_CLOCK
  };

  localparam logic [DATA_W-1:0] RESET_VALUE    = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_VALUE = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned ADC_GAIN_STEPS_LSB   = 0;
  localparam int unsigned ADC_GAIN_STEPS_W     = 3;
  localparam int unsigned ADC_GAIN_ENABLE_BIT  = 3;
  localparam int unsigned STEREO_CLOCK_LSB     = 4;
  localparam int unsigned STEREO_CLOCK_W       = 3;
  localparam int unsigned DAC_VOLUME_LSB       = 0;
  localparam int unsigned DAC_VOLUME_W         = 6;
  localparam int unsigned DAC_MUTE_BIT         = 7;
  localparam int unsigned EARPIECE_MUTE_BIT    = 0;
  localparam int unsigned HEADSET_RIGHT_BIT    = 1;
  localparam int unsigned HEADSET_LEFT_BIT     = 2;
  localparam int unsigned LEFT_MIX_AUDIO_BIT   = 4;
  localparam int unsigned LEFT_MIX_VOICE_BIT   = 5;
  localparam int unsigned LEFT_MIX_LINE_BIT    = 7;

  // stereo clock code after reset selects 26 MHz
  localparam logic [STEREO_CLOCK_W-1:0] STEREO_CLOCK_26MHZ = 3'h0;

  // ****************************************************************
  // serial frame: write flag, 10-bit address, 5 spare, 8 data, msb first
  // ****************************************************************
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_BITS  = 5'h18;
  localparam logic [CNT_W-1:0] HEADER_BITS = 5'h10;
  localparam int unsigned FRAME_W        = 24;
  localparam int unsigned HDR_WRITE_POS  = 15;
  localparam int unsigned HDR_ADDR_LSB   = 5;
  localparam int unsigned SYNC_STAGES_DEFAULT = 2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [STEREO_CLOCK_W-1:0]   stereo_clock_select;
    logic                        adc_gain_enable;
    logic [ADC_GAIN_STEPS_W-1:0] adc_gain_steps;
  } apc_adc_clock_type;

  typedef struct packed {
    logic                    mute;
    logic [DAC_VOLUME_W-1:0] volume;
  } apc_dac_type;

  typedef struct packed {
    logic earpiece_mute;
    logic headset_right_mute;
    logic headset_left_mute;
    logic left_mix_audio_dac;
    logic left_mix_voice_dac;
    logic left_mix_line_in;
  } apc_amp_mix_type;

  typedef struct packed {
    apc_adc_clock_type adc_clock;
    apc_dac_type       voice_dac;
    apc_dac_type       left_dac;
    apc_dac_type       right_dac;
    apc_amp_mix_type   amp_mix;
  } apc_audio_ctrl_type;

  typedef struct packed {
    logic             hit;
    logic [IDX_W-1:0] idx;
  } apc_decode_type;

endpackage : apc_pkg

`default_nettype wire

// file: hdl/apc_reg_cell.sv
// module: one masked 8-bit control register
`timescale 1ns/1ps
`default_nettype none

module apc_reg_cell #(
  parameter logic [apc_pkg::DATA_W-1:0] WRITE_MASK  = 8'hff,
  parameter logic [apc_pkg::DATA_W-1:0] RESET_VALUE = 8'h00
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       write_en,
  input  wire logic [apc_pkg::DATA_W-1:0] write_data,
  output var  logic [apc_pkg::DATA_W-1:0] value
);

  logic [apc_pkg::DATA_W-1:0] value_reg;
  logic [apc_pkg::DATA_W-1:0] value_next;

  always_comb begin
    value_next = value_reg;
    if (write_en) begin
      value_next = write_data & WRITE_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      value_reg <= RESET_VALUE & WRITE_MASK;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule : apc_reg_cell

`default_nettype wire

// file: hdl/apc_audio_path_control_regs.sv
// module: audio path control register bank behind the serial control port
`timescale 1ns/1ps
`default_nettype none

module apc_audio_path_control_regs #(
  parameter int unsigned SYNC_STAGES = apc_pkg::SYNC_STAGES_DEFAULT
) (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        spi_sclk,
  input  wire logic                        spi_cs_n,
  input  wire logic                        spi_mosi,
  output var  logic                        spi_miso_out,
  output var  logic                        spi_miso_oe_n,
  output var  apc_pkg::apc_audio_ctrl_type audio_ctrl
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end
  if (apc_pkg::FRAME_BITS != apc_pkg::FRAME_W) begin : g_bad_frame
    $error("frame bit count must match frame width");
  end
  if (apc_pkg::HEADER_BITS + apc_pkg::DATA_W != apc_pkg::FRAME_W) begin : g_bad_header
    $error("header plus data must fill the frame");
  end
  if (apc_pkg::HDR_ADDR_LSB + apc_pkg::ADDR_W > apc_pkg::HDR_WRITE_POS) begin : g_bad_addr
    $error("address field overlaps the write flag");
  end

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic apc_pkg::apc_decode_type decode_addr(input logic [apc_pkg::ADDR_W-1:0] addr);
    apc_pkg::apc_decode_type d;
    d.hit = 1'b0;
    d.idx = '0;
    for (int i = 0; i < apc_pkg::N_REGS; i++) begin
      if (addr == apc_pkg::REG_ADDRS[i]) begin
        d.hit = 1'b1;
        d.idx = apc_pkg::IDX_W'(i);
      end
    end
    return d;
  endfunction : decode_addr

  function automatic logic [apc_pkg::ADDR_W-1:0] header_addr(input logic [apc_pkg::HEADER_BITS-1:0] hdr);
    return hdr[apc_pkg::HDR_ADDR_LSB +: apc_pkg::ADDR_W];
  endfunction : header_addr

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [SYNC_STAGES-1:0][2:0] sync_reg;
  logic [SYNC_STAGES-1:0][2:0] sync_next;
  logic                        s_sclk;
  logic                        s_cs_n;
  logic                        s_mosi;

  always_comb begin
    sync_next    = sync_reg;
    sync_next[0] = {spi_mosi, spi_cs_n, spi_sclk};
    for (int i = 1; i < SYNC_STAGES; i++) begin
      sync_next[i] = sync_reg[i-1];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_reg <= {SYNC_STAGES{3'h2}};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign s_sclk = sync_reg[SYNC_STAGES-1][0];
  assign s_cs_n = sync_reg[SYNC_STAGES-1][1];
  assign s_mosi = sync_reg[SYNC_STAGES-1][2];

  // ****************************************************************
  // register bank
  // ****************************************************************
  logic [apc_pkg::N_REGS-1:0][apc_pkg::DATA_W-1:0] reg_value;
  logic                                            wr_reg;
  logic                                            wr_next;
  logic [apc_pkg::IDX_W-1:0]                       wr_idx_reg;
  logic [apc_pkg::IDX_W-1:0]                       wr_idx_next;
  logic [apc_pkg::DATA_W-1:0]                      wr_data_reg;
  logic [apc_pkg::DATA_W-1:0]                      wr_data_next;

  for (genvar g = 0; g < apc_pkg::N_REGS; g++) begin : g_cell
    apc_reg_cell #(
      .WRITE_MASK  (apc_pkg::WRITE_MASKS[g]),
      .RESET_VALUE (apc_pkg::RESET_VALUE)
    ) u_cell (
      .clk        (clk),
      .reset      (reset),
      .write_en   (wr_reg && (wr_idx_reg == apc_pkg::IDX_W'(g))),
      .write_data (wr_data_reg),
      .value      (reg_value[g])
    );
  end

  // ****************************************************************
  // serial frame engine
  // ****************************************************************
  logic                               sclk_prev_reg;
  logic                               sclk_prev_next;
  logic [apc_pkg::CNT_W-1:0]          count_reg;
  logic [apc_pkg::CNT_W-1:0]          count_next;
  logic [apc_pkg::FRAME_W-1:0]        shift_reg;
  logic [apc_pkg::FRAME_W-1:0]        shift_next;
  logic [apc_pkg::DATA_W-1:0]         tx_reg;
  logic [apc_pkg::DATA_W-1:0]         tx_next;
  logic                               miso_reg;
  logic                               miso_next;
  logic                               oe_n_reg;
  logic                               oe_n_next;
  logic                               sclk_rise;
  logic                               sclk_fall;
  logic [apc_pkg::FRAME_W-1:0]        frame_in;
  logic [apc_pkg::HEADER_BITS-1:0]    hdr_now;
  logic [apc_pkg::HEADER_BITS-1:0]    hdr_done;
  apc_pkg::apc_decode_type            rd_dec;
  apc_pkg::apc_decode_type            wr_dec;

  assign sclk_rise = s_sclk && !sclk_prev_reg;
  assign sclk_fall = !s_sclk && sclk_prev_reg;
  assign frame_in  = {shift_reg[apc_pkg::FRAME_W-2:0], s_mosi};
  assign hdr_now   = frame_in[apc_pkg::HEADER_BITS-1:0];
  assign hdr_done  = frame_in[apc_pkg::FRAME_W-1 -: apc_pkg::HEADER_BITS];
  assign rd_dec    = decode_addr(header_addr(hdr_now));
  assign wr_dec    = decode_addr(header_addr(hdr_done));

  // ****************************************************************
  // frame phase tracker
  // ****************************************************************
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_HEADER,
    PH_DATA,
    PH_DONE
  } apc_phase_type;

  apc_phase_type phase_reg;
  apc_phase_type phase_next;
  logic          data_phase;

  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      PH_IDLE: begin
        if (!s_cs_n) begin
          phase_next = PH_HEADER;
        end
      end
      PH_HEADER: begin
        if (s_cs_n) begin
          phase_next = PH_IDLE;
        end else if (sclk_rise && (count_reg == apc_pkg::HEADER_BITS - 1'b1)) begin
          phase_next = PH_DATA;
        end
      end
      PH_DATA: begin
        if (s_cs_n) begin
          phase_next = PH_IDLE;
        end else if (sclk_rise && (count_reg == apc_pkg::FRAME_BITS - 1'b1)) begin
          phase_next = PH_DONE;
        end
      end
      PH_DONE: begin
        if (s_cs_n) begin
          phase_next = PH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_reg <= PH_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // read data shifts only in the data phase
  assign data_phase = (phase_reg == PH_DATA);

  always_comb begin
    sclk_prev_next = s_sclk;
    count_next     = count_reg;
    shift_next     = shift_reg;
    tx_next        = tx_reg;
    miso_next      = miso_reg;
    oe_n_next      = s_cs_n;
    wr_next        = 1'b0;
    wr_idx_next    = wr_idx_reg;
    wr_data_next   = wr_data_reg;
    if (s_cs_n) begin
      count_next = '0;
      miso_next  = 1'b0;
    end else begin
      if (sclk_rise && (count_reg < apc_pkg::FRAME_BITS)) begin
        shift_next = frame_in;
        count_next = apc_pkg::CNT_W'(count_reg + 1'b1);
        if (count_reg == apc_pkg::HEADER_BITS - 1'b1) begin
          // readback of implemented bits only; reserved read as zero
          tx_next = rd_dec.hit ? reg_value[rd_dec.idx] : apc_pkg::UNMAPPED_VALUE;
        end
        if ((count_reg == apc_pkg::FRAME_BITS - 1'b1) && hdr_done[apc_pkg::HDR_WRITE_POS] && wr_dec.hit) begin
          wr_next      = 1'b1;
          wr_idx_next  = wr_dec.idx;
          wr_data_next = frame_in[apc_pkg::DATA_W-1:0];
        end
      end
      if (sclk_fall && data_phase) begin
        miso_next = tx_reg[apc_pkg::DATA_W-1];
        tx_next   = {tx_reg[apc_pkg::DATA_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_prev_reg <= 1'b0;
      count_reg     <= '0;
      shift_reg     <= '0;
      tx_reg        <= apc_pkg::RESET_VALUE;
      miso_reg      <= 1'b0;
      oe_n_reg      <= 1'b1;
      wr_reg        <= 1'b0;
      wr_idx_reg    <= '0;
      wr_data_reg   <= apc_pkg::RESET_VALUE;
    end else begin
      sclk_prev_reg <= sclk_prev_next;
      count_reg     <= count_next;
      shift_reg     <= shift_next;
      tx_reg        <= tx_next;
      miso_reg      <= miso_next;
      oe_n_reg      <= oe_n_next;
      wr_reg        <= wr_next;
      wr_idx_reg    <= wr_idx_next;
      wr_data_reg   <= wr_data_next;
    end
  end

  assign spi_miso_out  = miso_reg;
  assign spi_miso_oe_n = oe_n_reg;

  // ****************************************************************
  // control outputs
  // ****************************************************************
  logic [apc_pkg::DATA_W-1:0] r_adc;
  logic [apc_pkg::DATA_W-1:0] r_voice;
  logic [apc_pkg::DATA_W-1:0] r_left;
  logic [apc_pkg::DATA_W-1:0] r_right;
  logic [apc_pkg::DATA_W-1:0] r_amp;

  assign r_adc   = reg_value[apc_pkg::IDX_ADC_GAIN_AND_STEREO_CLOCK];
  assign r_voice = reg_value[apc_pkg::IDX_VOICE_DAC_VOLUME_MUTE];
  assign r_left  = reg_value[apc_pkg::IDX_LEFT_DAC_VOLUME_MUTE];
  assign r_right = reg_value[apc_pkg::IDX_RIGHT_DAC_VOLUME_MUTE];
  assign r_amp   = reg_value[apc_pkg::IDX_AMP_MUTE_LEFT_MIXER];

  assign audio_ctrl.adc_clock.adc_gain_steps      = r_adc[apc_pkg::ADC_GAIN_STEPS_LSB +: apc_pkg::ADC_GAIN_STEPS_W];
  assign audio_ctrl.adc_clock.adc_gain_enable     = r_adc[apc_pkg::ADC_GAIN_ENABLE_BIT];
  assign audio_ctrl.adc_clock.stereo_clock_select = r_adc[apc_pkg::STEREO_CLOCK_LSB +: apc_pkg::STEREO_CLOCK_W];
  assign audio_ctrl.voice_dac.volume              = r_voice[apc_pkg::DAC_VOLUME_LSB +: apc_pkg::DAC_VOLUME_W];
  assign audio_ctrl.voice_dac.mute                = r_voice[apc_pkg::DAC_MUTE_BIT];
  assign audio_ctrl.left_dac.volume               = r_left[apc_pkg::DAC_VOLUME_LSB +: apc_pkg::DAC_VOLUME_W];
  assign audio_ctrl.left_dac.mute                 = r_left[apc_pkg::DAC_MUTE_BIT];
  assign audio_ctrl.right_dac.volume              = r_right[apc_pkg::DAC_VOLUME_LSB +: apc_pkg::DAC_VOLUME_W];
  assign audio_ctrl.right_dac.mute                = r_right[apc_pkg::DAC_MUTE_BIT];
  assign audio_ctrl.amp_mix.earpiece_mute         = r_amp[apc_pkg::EARPIECE_MUTE_BIT];
  assign audio_ctrl.amp_mix.headset_right_mute    = r_amp[apc_pkg::HEADSET_RIGHT_BIT];
  assign audio_ctrl.amp_mix.headset_left_mute     = r_amp[apc_pkg::HEADSET_LEFT_BIT];
  assign audio_ctrl.amp_mix.left_mix_audio_dac    = r_amp[apc_pkg::LEFT_MIX_AUDIO_BIT];
  assign audio_ctrl.amp_mix.left_mix_voice_dac    = r_amp[apc_pkg::LEFT_MIX_VOICE_BIT];
  assign audio_ctrl.amp_mix.left_mix_line_in      = r_amp[apc_pkg::LEFT_MIX_LINE_BIT];

endmodule : apc_audio_path_control_regs

`default_nettype wire

// file: test/apc_regs_checker.sv
// checker: port-level assertions for the audio path control register bank
`timescale 1ns/1ps
`default_nettype none

module apc_regs_checker #(
  parameter int unsigned SYNC_STAGES = 2
) (
  input wire logic                        clk,
  input wire logic                        reset,
  input wire logic                        spi_sclk,
  input wire logic                        spi_cs_n,
  input wire logic                        spi_mosi,
  input wire logic                        spi_miso_out,
  input wire logic                        spi_miso_oe_n,
  input wire apc_pkg::apc_audio_ctrl_type audio_ctrl
);
  // ****************************************************************
  // helper counters: cycles since select high, since sclk rise
  // ****************************************************************
  localparam int QUIET_MAX = SYNC_STAGES + 7;
  logic [7:0] idle_reg, idle_next, rise_reg, rise_next;
  logic       sclk_prev_reg, sclk_prev_next;

  always_comb begin
    idle_next      = spi_cs_n ? ((idle_reg == 8'hff) ? idle_reg : idle_reg + 8'h01) : 8'h00;
    rise_next      = (spi_sclk && !sclk_prev_reg) ? 8'h00 : ((rise_reg == 8'hff) ? rise_reg : rise_reg + 8'h01);
    sclk_prev_next = spi_sclk;
    if (reset) begin
      idle_next = 8'hff;
      rise_next = 8'hff;
    end
  end

  always_ff @(posedge clk) begin
    idle_reg      <= idle_next;
    rise_reg      <= rise_next;
    sclk_prev_reg <= sclk_prev_next;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  reset_clear_a: assert property ($fell(reset) |-> audio_ctrl == '0)
    else $error("controls not zero after reset");
  clock_default_a: assert property ($fell(reset) |-> audio_ctrl.adc_clock.stereo_clock_select == apc_pkg::STEREO_CLOCK_26MHZ)
    else $error("stereo clock select not at reset code");
  frame_only_a: assert property (!$stable(audio_ctrl) |-> idle_reg < QUIET_MAX)
    else $error("controls changed outside a frame");
  sclk_cause_a: assert property (!$stable(audio_ctrl) |-> rise_reg < QUIET_MAX)
    else $error("controls changed without a serial clock edge");
  one_register_a: assert property (!$stable(audio_ctrl) |-> $onehot({!$stable(audio_ctrl.adc_clock),
    !$stable(audio_ctrl.voice_dac), !$stable(audio_ctrl.left_dac), !$stable(audio_ctrl.right_dac),
    !$stable(audio_ctrl.amp_mix)})) else $error("one write changed several registers");
  oe_idle_a: assert property (spi_cs_n [*4] |-> spi_miso_oe_n)
    else $error("data out enabled while deselected");
  oe_drive_a: assert property (!spi_cs_n [*4] |-> !spi_miso_oe_n)
    else $error("data out not enabled while selected");
  miso_idle_a: assert property (spi_cs_n [*4] |-> !spi_miso_out)
    else $error("data out not low while deselected");
  miso_steady_a: assert property (spi_sclk [*5] |-> $stable(spi_miso_out))
    else $error("data out moved while serial clock high");

  write_seen_c: cover property (!$stable(audio_ctrl));
  read_one_c: cover property ($rose(spi_miso_out));
  frame_end_c: cover property ($rose(spi_cs_n));
endmodule : apc_regs_checker

bind apc_audio_path_control_regs apc_regs_checker #(.SYNC_STAGES(SYNC_STAGES)) u_apc_regs_checker (
  .clk(clk), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
  .spi_miso_out(spi_miso_out), .spi_miso_oe_n(spi_miso_oe_n), .audio_ctrl(audio_ctrl));

`default_nettype wire

// file: test/testbench.sv
// testbench: serial register access scenarios for the audio path control bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                        clk, reset, spi_sclk, spi_cs_n, spi_mosi, spi_miso_out, spi_miso_oe_n;
  apc_pkg::apc_audio_ctrl_type audio_ctrl, exp_ctrl;
  int                          err_total, checks_done;
  logic [7:0]                  rd;
  logic [9:0]                  addrs [5] = '{10'h18d, 10'h18e, 10'h18f, 10'h190, 10'h191};
  logic [7:0]                  masks [5] = '{8'h7f, 8'hbf, 8'hbf, 8'hbf, 8'hb7};
  logic [7:0]                  pats [4]  = '{8'hff, 8'ha5, 8'h5a, 8'h00};

  apc_audio_path_control_regs #(.SYNC_STAGES(2)) u_apc_audio_path_control_regs (
    .clk(clk), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso_out(spi_miso_out), .spi_miso_oe_n(spi_miso_oe_n), .audio_ctrl(audio_ctrl));

  always #5 clk = ~clk;

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t data out enable %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_ctrl();
    checks_done++;
    if (audio_ctrl !== exp_ctrl) begin
      err_total++;
      $display("[ERR] %0t controls %h expected %h", $time, audio_ctrl, exp_ctrl);
    end
  endtask : cmp_ctrl

  task automatic spi_frame(input logic [23:0] frm, input int nbits);
    @(posedge clk) spi_cs_n <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk) spi_mosi <= frm[23-i];
      repeat (4) @(posedge clk);
      @(posedge clk) spi_sclk <= 1'b1;
      if (i >= 16) rd[23-i] = spi_miso_out;
      cmp_bit(spi_miso_oe_n, 1'b0);
      repeat (4) @(posedge clk);
      @(posedge clk) spi_sclk <= 1'b0;
    end
    repeat (5) @(posedge clk);
    @(posedge clk) spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
    repeat (6) @(posedge clk);
    cmp_bit(spi_miso_oe_n, 1'b1);
  endtask : spi_frame

  task automatic write_reg(input int idx, input logic [7:0] d);
    spi_frame({1'b1, addrs[idx], 5'h00, d}, 24);
    case (idx)
      0: exp_ctrl.adc_clock = {d[6:4], d[3], d[2:0]};
      1: exp_ctrl.voice_dac = {d[7], d[5:0]};
      2: exp_ctrl.left_dac = {d[7], d[5:0]};
      3: exp_ctrl.right_dac = {d[7], d[5:0]};
      default: exp_ctrl.amp_mix = {d[0], d[1], d[2], d[4], d[5], d[7]};
    endcase
    cmp_ctrl();
  endtask : write_reg

  task automatic read_reg(input logic [9:0] addr, input logic [7:0] exp);
    spi_frame({1'b0, addr, 5'h00, 8'h00}, 24);
    cmp_byte(rd, exp);
  endtask : read_reg

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset_state();
    cmp_ctrl();
    for (int i = 0; i < 5; i++) read_reg(addrs[i], 8'h00);
  endtask : t_reset_state

  task automatic t_field_walk();
    for (int i = 0; i < 5; i++) begin
      for (int p = 0; p < 4; p++) begin
        write_reg(i, pats[p]);
        read_reg(addrs[i], pats[p] & masks[i]);
      end
    end
    for (int i = 0; i < 5; i++) write_reg(i, 8'hff);
  endtask : t_field_walk

  task automatic t_unmapped();
    spi_frame({1'b1, 10'h18c, 5'h00, 8'h00}, 24);
    spi_frame({1'b1, 10'h192, 5'h00, 8'h00}, 24);
    cmp_ctrl();
    read_reg(10'h192, 8'h00);
  endtask : t_unmapped

  task automatic t_abort();
    spi_frame({1'b1, addrs[1], 5'h00, 8'h00}, 23);
    cmp_ctrl();
    read_reg(addrs[1], 8'hbf);
  endtask : t_abort

  task automatic t_reset_mid();
    @(posedge clk) reset <= 1'b1;
    repeat (4) @(posedge clk);
    @(posedge clk) reset <= 1'b0;
    repeat (4) @(posedge clk);
    exp_ctrl = '0;
    cmp_ctrl();
    read_reg(addrs[4], 8'h00);
  endtask : t_reset_mid

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    exp_ctrl = '0;
    rd = 8'h00;
    err_total = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset_state();
    t_field_walk();
    t_unmapped();
    t_abort();
    t_reset_mid();
    report_and_stop();
  end

  initial begin
    #500us;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
